// ===== imte_top.sv
// What this block does
// - serial data goes out on the line number held in sda_line_select
// - serial clock goes out on the line number held in scl_line_select
// - divisor sets bit rate; zero counts as 65536, the fastest rate
// - option bit 0 adds a bus reset sequence before each transaction
// - option bit 1 picks repeated start, else stop then start, at turnaround
// - option bit 2 ignores a target holding the clock low
// - address byte is the 7-bit address shifted left plus read/write bit
// - send tx_byte_count data bytes; zero gives a read-only transaction
// - read rx_byte_count bytes; zero gives a write-only transaction
// - transmit buffer holds payload only; engine makes the address byte
// - the whole write phase ends before any read phase starts
// - a write to transfer_trigger while idle launches one full transaction if either byte count is nonzero
// - received bytes are buffered; reading past them gives zero
// - order is address-write, data, address-read, data; empty phases lose address
// - only bytes the engine sends add to ack_history
// - per sent byte, history shifts left and bit 0 takes 1 for ack
// - a stretched clock is waited on for up to 1000 clock periods
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module imte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full and empty come from the occupancy count
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_ready_i && out_valid_o && !flush_i;

  // storage has no reset; only pointers and count need a known value
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap on a power-of-two depth
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // imte_fifo

////////////////////////////////////////////////////////////////////////////////
module imte_top import imte_pkg::*; #(
  parameter int NLINES = 8,
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic tx_buf_ready_o,
  output logic busy_o,
  input wire logic [NLINES-1:0] line_in_i,
  output logic [NLINES-1:0] line_out_o,
  output logic [NLINES-1:0] line_oe_o
);
  localparam int RW = $clog2(RX_DEPTH);

  logic [15:0] sda_line_select;
  logic [15:0] scl_line_select;
  logic [15:0] bit_rate_divisor;
  logic [15:0] protocol_options;
  logic [15:0] target_address;
  logic [15:0] tx_byte_count;
  logic [15:0] rx_byte_count;
  logic [15:0] transfer_trigger;
  logic [31:0] ack_history;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [RW:0] rx_stored;
  logic [RW:0] rx_rd_ptr;
  logic [NLINES-1:0] sync1;
  logic [NLINES-1:0] sync2;
  logic sda_in;
  logic scl_in;
  imte_state_t st;
  imte_seg_t seg;
  logic [1:0] q;
  logic [3:0] bcnt;
  logic [20:0] qlen;
  logic [20:0] qtmr;
  logic [11:0] stretch_cnt;
  logic [15:0] tx_left;
  logic [15:0] rx_left;
  logic [7:0] shreg;
  logic restart;
  logic sda_low;
  logic scl_low;
  logic go;
  logic tick;
  logic stall;
  logic adv;
  logic hold;
  logic tmo;
  logic byte_end;
  logic load_tx;
  logic ack_rec;
  logic rx_store;
  logic done;
  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // level seen on a selected line; an out-of-range number reads as released
  function automatic logic line_level(input logic [NLINES-1:0] lv, input logic [15:0] sel);
    logic r;
    r = 1'b1;
    for (int i = 0; i < NLINES; i++) begin
      if (sel == 16'(i)) r = lv[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pins come from outside the clock domain; two flops before any use
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= line_in_i;
      sync2 <= sync1;
    end
  end

  assign sda_in = line_level(sync2, sda_line_select);
  assign scl_in = line_level(sync2, scl_line_select);

  // open drain: output level is always low, the enable pulls the line
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_out_o <= '0;
      line_oe_o <= '0;
    end else begin
      line_out_o <= '0;
      for (int i = 0; i < NLINES; i++) begin
        line_oe_o[i] <= (sda_low && sda_line_select == 16'(i)) ||
                        (scl_low && scl_line_select == 16'(i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration is global and kept across transactions
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_line_select <= CFG_RESET;
      scl_line_select <= CFG_RESET;
      bit_rate_divisor <= DIV_RESET;
      protocol_options <= CFG_RESET;
      target_address <= CFG_RESET;
      tx_byte_count <= CFG_RESET;
      rx_byte_count <= CFG_RESET;
      transfer_trigger <= CFG_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_SDA_SEL: sda_line_select <= reg_wdata_i[15:0];
        OFS_SCL_SEL: scl_line_select <= reg_wdata_i[15:0];
        OFS_DIVISOR: bit_rate_divisor <= reg_wdata_i[15:0];
        OFS_OPTIONS: protocol_options <= reg_wdata_i[15:0];
        OFS_ADDRESS: target_address <= reg_wdata_i[15:0];
        OFS_TX_COUNT: tx_byte_count <= reg_wdata_i[15:0];
        OFS_RX_COUNT: rx_byte_count <= reg_wdata_i[15:0];
        OFS_TRIGGER: transfer_trigger <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // a trigger while busy is dropped so a running transfer is never torn
  assign go = reg_wr_i && reg_addr_i == OFS_TRIGGER && st == S_IDLE;

  // history: a hardware shift wins over a software write in the same cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_history <= ACK_RESET;
    end else if (ack_rec) begin
      ack_history <= {ack_history[30:0], !sda_in};
    end else if (reg_wr_i && reg_addr_i == OFS_ACK_HIST) begin
      ack_history <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload bytes only; the engine drains it one byte per data slot
  imte_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(done),
    .in_valid_i(reg_wr_i && reg_addr_i == OFS_TX_PORT),
    .in_data_i(reg_wdata_i[7:0]),
    .in_ready_o(fifo_ready),
    .out_ready_i(load_tx),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data)
  );

  // receive store; bytes beyond the depth are dropped
  always_ff @(posedge ref_clk_i) begin
    if (rx_store && rx_stored < (RW+1)'(RX_DEPTH)) begin
      rx_mem[rx_stored[RW-1:0]] <= shreg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_stored <= '0;
    end else if (go) begin
      rx_stored <= '0;
    end else if (rx_store && rx_stored < (RW+1)'(RX_DEPTH)) begin
      rx_stored <= rx_stored + 1'b1;
    end
  end

  // register reads answer one cycle later; the receive port pops a byte
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
      rx_rd_ptr <= '0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (go) rx_rd_ptr <= '0;
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          OFS_SDA_SEL: reg_rdata_o <= {16'h0000, sda_line_select};
          OFS_SCL_SEL: reg_rdata_o <= {16'h0000, scl_line_select};
          OFS_DIVISOR: reg_rdata_o <= {16'h0000, bit_rate_divisor};
          OFS_OPTIONS: reg_rdata_o <= {16'h0000, protocol_options};
          OFS_ADDRESS: reg_rdata_o <= {16'h0000, target_address};
          OFS_TX_COUNT: reg_rdata_o <= {16'h0000, tx_byte_count};
          OFS_RX_COUNT: reg_rdata_o <= {16'h0000, rx_byte_count};
          OFS_TRIGGER: reg_rdata_o <= {16'h0000, transfer_trigger};
          OFS_ACK_HIST: reg_rdata_o <= ack_history;
          OFS_RX_PORT: begin
            if (rx_rd_ptr < rx_stored) begin
              reg_rdata_o <= {24'h000000, rx_mem[rx_rd_ptr[RW-1:0]]};
              if (!go) rx_rd_ptr <= rx_rd_ptr + 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // status outputs lag the engine by one cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      tx_buf_ready_o <= 1'b0;
    end else begin
      busy_o <= (st != S_IDLE);
      tx_buf_ready_o <= fifo_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter timing; the clock-high check sits at the end of quarter 2
  assign tick = (qtmr == qlen - 21'd1);
  assign stall = st != S_IDLE && q == 2'd2 && !scl_in &&
                 !protocol_options[OPT_NO_STRETCH];
  assign tmo = tick && stall && stretch_cnt == 12'(STRETCH_QUARTERS - 1);
  assign hold = tick && stall && !tmo;
  assign adv = tick && !stall;
  assign byte_end = st == S_BIT && adv && q == 2'd3 && bcnt == LAST_BIT;
  assign load_tx = byte_end && seg != SEG_ADDR_R && seg != SEG_RX && tx_left != 16'h0000;
  assign ack_rec = st == S_BIT && adv && q == 2'd2 && bcnt == LAST_BIT &&
                   seg != SEG_RX;
  assign rx_store = byte_end && seg == SEG_RX;
  assign done = (st == S_STOP && adv && q == 2'd3 && !restart) || tmo;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qtmr <= '0;
      stretch_cnt <= '0;
      qlen <= '0;
    end else begin
      if (go) qlen <= imte_quarter_len(bit_rate_divisor);
      qtmr <= (st == S_IDLE || tick) ? 21'd0 : qtmr + 21'd1;
      if (hold) stretch_cnt <= stretch_cnt + 12'd1;
      else if (adv || st == S_IDLE) stretch_cnt <= '0;
    end
  end

  // transaction sequencer: reset, start, bytes, turnaround, stop
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= S_IDLE;
      seg <= SEG_ADDR_W;
      q <= '0;
      bcnt <= '0;
      tx_left <= '0;
      rx_left <= '0;
      shreg <= '0;
      restart <= 1'b0;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
    end else if (tmo) begin
      // a clock held past the limit ends the transfer with a stop attempt
      st <= (st == S_STOP) ? S_IDLE : S_STOP;
      q <= '0;
      restart <= 1'b0;
    end else if (st == S_IDLE) begin
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      if (go && (tx_byte_count != 16'h0000 || rx_byte_count != 16'h0000)) begin
        tx_left <= tx_byte_count;
        rx_left <= rx_byte_count;
        seg <= (tx_byte_count != 16'h0000) ? SEG_ADDR_W : SEG_ADDR_R;
        st <= protocol_options[OPT_BUS_RESET] ? S_RST : S_START;
        restart <= protocol_options[OPT_BUS_RESET];
        q <= '0;
        bcnt <= '0;
      end
    end else if (adv) begin
      q <= q + 2'd1;
      case (st)
        S_RST: begin
          // free-running clocks with data released unstick a target
          case (q)
            2'd0: sda_low <= 1'b0;
            2'd1: scl_low <= 1'b0;
            2'd3: begin
              scl_low <= 1'b1;
              bcnt <= bcnt + 4'd1;
              if (bcnt == 4'(RESET_CLOCKS - 1)) begin
                st <= S_STOP;
                bcnt <= '0;
              end
            end
            default: ;
          endcase
        end
        S_START: begin
          case (q)
            2'd0: sda_low <= 1'b0;
            2'd1: scl_low <= 1'b0;
            2'd2: sda_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              st <= S_BIT;
              bcnt <= '0;
              shreg <= {target_address[6:0], seg == SEG_ADDR_R};
            end
          endcase
        end
        S_BIT: begin
          case (q)
            2'd0: begin
              if (seg == SEG_RX) begin
                sda_low <= (bcnt == LAST_BIT) && rx_left != 16'h0001;
              end else begin
                sda_low <= (bcnt != LAST_BIT) && !shreg[7];
              end
            end
            2'd1: scl_low <= 1'b0;
            2'd2: if (bcnt != LAST_BIT) shreg <= {shreg[6:0], sda_in};
            default: begin
              scl_low <= 1'b1;
              bcnt <= bcnt + 4'd1;
              if (bcnt == LAST_BIT) begin
                bcnt <= '0;
                case (seg)
                  SEG_ADDR_W, SEG_TX: begin
                    if (tx_left != 16'h0000) begin
                      // an empty buffer sends zero bytes rather than stalling the bus
                      shreg <= fifo_valid ? fifo_data : 8'h00;
                      seg <= SEG_TX;
                      tx_left <= tx_left - 16'h0001;
                    end else if (rx_left != 16'h0000 &&
                                 protocol_options[OPT_REPEAT_START]) begin
                      st <= S_START;
                      seg <= SEG_ADDR_R;
                    end else begin
                      st <= S_STOP;
                      seg <= SEG_ADDR_R;
                      restart <= (rx_left != 16'h0000);
                    end
                  end
                  SEG_ADDR_R: seg <= SEG_RX;
                  SEG_RX: begin
                    rx_left <= rx_left - 16'h0001;
                    if (rx_left == 16'h0001) st <= S_STOP;
                  end
                  default: ;
                endcase
              end
            end
          endcase
        end
        S_STOP: begin
          case (q)
            2'd0: sda_low <= 1'b1;
            2'd1: scl_low <= 1'b0;
            2'd2: sda_low <= 1'b0;
            default: begin
              restart <= 1'b0;
              st <= restart ? S_START : S_IDLE;
            end
          endcase
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_idle_release: assert property (st == S_IDLE ##1 st == S_IDLE |=> line_oe_o == '0)
    else $error("lines pulled while idle");
  a_zero_divisor: assert property (go && bit_rate_divisor == 16'h0000 |=> qlen == 21'd60)
    else $error("zero divisor not treated as 65536");
  a_trig_launch: assert property (go && rx_byte_count != 16'h0000 |=> st != S_IDLE)
    else $error("trigger did not launch a transaction");
  a_ack_shift: assert property (ack_rec |=> ack_history == {$past(ack_history[30:0]),
                                                             !$past(sda_in)})
    else $error("ack history not shifted with new ack");
  a_rx_no_hist: assert property (st == S_BIT && seg == SEG_RX && adv && q == 2'd2 &&
                                 bcnt == LAST_BIT && !(reg_wr_i && reg_addr_i == OFS_ACK_HIST)
                                 |=> $stable(ack_history))
    else $error("received byte recorded in ack history");
  a_write_first: assert property (seg == SEG_ADDR_R || seg == SEG_RX |-> tx_left == 16'h0000)
    else $error("read phase entered with data left to send");
  a_nack_last: assert property (st == S_BIT && seg == SEG_RX && bcnt == LAST_BIT &&
                                rx_left == 16'h0001 && q == 2'd1 |-> !sda_low)
    else $error("last received byte was acked");
  a_addr_byte: assert property (st == S_START && adv && q == 2'd3 |=>
                                shreg == {target_address[6:0], seg == SEG_ADDR_R})
    else $error("address byte not shifted with rw bit");
  a_rx_underrun: assert property (reg_rd_i && reg_addr_i == OFS_RX_PORT && !go &&
                                  rx_rd_ptr >= rx_stored |=> reg_rdata_o == 32'h0)
    else $error("rx underrun did not read zero");
  a_no_stretch: assert property (protocol_options[OPT_NO_STRETCH] && st == S_BIT &&
                                 q == 2'd2 && tick |=> q == 2'd3)
    else $error("stretch honoured while disabled");
  a_stretch_cap: assert property (stretch_cnt == 12'(STRETCH_QUARTERS - 1) && tick && stall
                                  |=> st == S_STOP || st == S_IDLE)
    else $error("stretch wait exceeded limit");
  a_reset_first: assert property (go && protocol_options[OPT_BUS_RESET] &&
                                  tx_byte_count != 16'h0000 |=> st == S_RST)
    else $error("bus reset not issued first");

endmodule // imte_top

// ===== imte_pkg.sv
package imte_pkg;

  // register indices on the register port
  localparam logic [15:0] OFS_SDA_SEL = 16'h13ec;
  localparam logic [15:0] OFS_SCL_SEL = 16'h13ed;
  localparam logic [15:0] OFS_DIVISOR = 16'h13ee;
  localparam logic [15:0] OFS_OPTIONS = 16'h13ef;
  localparam logic [15:0] OFS_ADDRESS = 16'h13f0;
  localparam logic [15:0] OFS_TX_COUNT = 16'h13f4;
  localparam logic [15:0] OFS_RX_COUNT = 16'h13f5;
  localparam logic [15:0] OFS_TRIGGER = 16'h13f6;
  localparam logic [15:0] OFS_ACK_HIST = 16'h13fa;
  localparam logic [15:0] OFS_TX_PORT = 16'h1400;
  localparam logic [15:0] OFS_RX_PORT = 16'h1428;

  // option bit positions
  localparam int OPT_BUS_RESET = 0;
  localparam int OPT_REPEAT_START = 1;
  localparam int OPT_NO_STRETCH = 2;

  // values after reset
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [31:0] ACK_RESET = 32'h0000_0000;

  // bit timing: quarter period = (65536 - divisor + base) steps of STEP_NS
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_NS = 100;
  localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_BASE = 6;
  localparam logic [16:0] DIV_ZERO_AS = 17'h10000;
  localparam int QUARTERS = 4;
  localparam int STRETCH_PERIODS = 1000;
  localparam int STRETCH_QUARTERS = STRETCH_PERIODS * QUARTERS;
  localparam int RESET_CLOCKS = 9;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [2:0] {S_IDLE, S_RST, S_START, S_BIT, S_STOP} imte_state_t;
  typedef enum logic [1:0] {SEG_ADDR_W, SEG_TX, SEG_ADDR_R, SEG_RX} imte_seg_t;

  // quarter bit length in clock cycles; zero divisor stands for 65536
  function automatic logic [20:0] imte_quarter_len(input logic [15:0] div);
    logic [16:0] d;
    d = (div == 16'h0000) ? DIV_ZERO_AS : {1'b0, div};
    return 21'(DIV_ZERO_AS - d + 17'(STEP_BASE)) * 21'(STEP_CYCLES);
  endfunction

endpackage

// ===== imte_target.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// bus target: acks its address and written bytes, serves a count-up on reads;
// it never stretches, so the clock wire is only ever driven by the engine
module imte_target #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic [7:0] rd_base_i,
  output logic sda_pull_o,
  output logic byte_valid_o,
  output logic [8:0] byte_o
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic pull = 1'b0;
  logic bv = 1'b0;
  logic nack = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] out_sh = 8'h00;
  logic [7:0] rd_n = 8'h00;
  logic [8:0] got = 9'h000;
  wire logic [7:0] nb = rd_base_i + rd_n;
  assign sda_pull_o = pull;
  assign byte_valid_o = bv;
  assign byte_o = got;
  // wires sampled on the fast clock; phase 1 address, 2 write, 3 read; stop is 9'h100
  always @(posedge ref_clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    bv <= 1'b0;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      phase <= 2'h1;
      // the clock fall that closes the start is no data bit; it wraps to 0
      bitn <= 4'h8;
      pull <= 1'b0;
      rd_n <= 8'h00;
    end else if (scl_i && scl_q && !sda_q && sda_i) begin
      phase <= 2'h0;
      pull <= 1'b0;
      bv <= 1'b1;
      got <= 9'h100;
    end else if (scl_i && !scl_q) begin
      if (bitn < 4'h8) sh <= {sh[6:0], sda_i};
      else nack <= sda_i;
    end else if (!scl_i && scl_q && phase != 2'h0) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h7) begin
        bv <= (phase != 2'h3);
        got <= {1'b0, sh};
        nack <= 1'b0;
        pull <= (phase == 2'h2) || (phase == 2'h1 && sh[7:1] == ADDR);
        if (phase == 2'h1) phase <= (sh[7:1] != ADDR) ? 2'h0 : (sh[0] ? 2'h3 : 2'h2);
      end else if (bitn == 4'h8 && phase == 2'h3 && !nack) begin
        out_sh <= nb;
        pull <= !nb[7];
        rd_n <= rd_n + 8'h01;
      end else if (phase == 2'h3 && bitn < 4'h7) pull <= !out_sh[3'h6 - bitn[2:0]];
      else pull <= 1'b0;
    end
  end
endmodule // imte_target

// ===== test_imte_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h", $time, a); end end
////////////////////////////////////////////////////////////////////////////////
module test_imte_top;
  import imte_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic rvalid, txr, busy, pull, bv;
  logic scl_q = 1'b1;
  logic [7:0] oe, lvl, b, lo;
  logic [7:0] base = 8'h00;
  logic [8:0] bus_byte;
  logic [2:0] sda_n = 3'h0;
  logic [2:0] scl_n = 3'h1;
  logic [31:0] exp_reg[$];
  logic [8:0] exp_bus[$];
  int gap = 0;
  int min_gap = 99999;
  int fail_count = 0;
  int comparisons = 0;
  // open-drain wires with pull-ups; the target only pulls the data wire
  always_comb for (int i = 0; i < 8; i++) lvl[i] = !(oe[i] || (pull && sda_n == i));
  imte_top i_dut (.ref_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .tx_buf_ready_o(txr), .busy_o(busy), .line_in_i(lvl), .line_out_o(lo), .line_oe_o(oe));
  imte_target i_tgt (.ref_clk_i(clk), .sda_i(lvl[sda_n]), .scl_i(lvl[scl_n]),
    .rd_base_i(base), .sda_pull_o(pull), .byte_valid_o(bv), .byte_o(bus_byte));
  initial forever #5 clk = !clk;
  // answers are held against the oldest note; also tracks the shortest clock period
  always @(posedge clk) begin
    if (rvalid === 1'b1) `CHK(rdata, exp_reg.pop_front())
    if (bv === 1'b1) `CHK(bus_byte, exp_bus.pop_front())
    if (busy === 1'b1) `CHK({lo, oe & ~((8'h1 << sda_n) | (8'h1 << scl_n))}, 16'h0000)
    scl_q <= lvl[scl_n];
    gap <= gap + 1;
    if (lvl[scl_n] && !scl_q) begin
      gap <= 1;
      if (gap < min_gap) min_gap <= gap;
    end
  end
  task automatic test_done();
    $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rdx(input logic [15:0] a, input logic [31:0] e);
    exp_reg.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        fail_count++;
        test_done();
      end
    end
  endtask
  // counts, then a trigger of random value; waits for the transaction to finish
  task automatic run(input logic [15:0] tx, input logic [15:0] rx);
    acc(1'b1, OFS_TX_COUNT, {16'h0, tx});
    acc(1'b1, OFS_RX_COUNT, {16'h0, rx});
    acc(1'b1, OFS_TRIGGER, {16'h0, 16'($urandom())});
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 60000);
    // every noted bus byte must have been seen before the next notes are loaded
    `CHK(exp_bus.size(), 0)
  endtask
  initial begin
    base = 8'($urandom(3));
    sda_n = 3'($urandom());
    scl_n = sda_n + 3'($urandom_range(7, 1));
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    // reset values; unmapped place and write-only port read as zero
    rdx(OFS_DIVISOR, {16'h0, DIV_RESET});
    rdx(OFS_OPTIONS, {16'h0, CFG_RESET});
    rdx(OFS_ACK_HIST, ACK_RESET);
    rdx(16'h13f1, 32'h0);
    rdx(OFS_TX_PORT, 32'h0);
    acc(1'b1, OFS_SDA_SEL, {29'h0, sda_n});
    acc(1'b1, OFS_SCL_SEL, {29'h0, scl_n});
    acc(1'b1, OFS_ADDRESS, 32'h2a);
    rdx(OFS_SCL_SEL, {29'h0, scl_n});
    // full buffer refuses the extra byte; stop then start at the turn
    exp_bus.push_back(9'h054);
    for (int i = 0; i < 17; i++) begin
      b = 8'($urandom());
      acc(1'b1, OFS_TX_PORT, {24'h0, b});
      if (i < 16) exp_bus.push_back({1'b0, b});
    end
    `CHK(txr, 1'b0)
    exp_bus.push_back(9'h100);
    exp_bus.push_back(9'h055);
    exp_bus.push_back(9'h100);
    run(16'd16, 16'd2);
    `CHK(min_gap, QUARTERS * STEP_BASE * STEP_CYCLES)
    `CHK(txr, 1'b1)
    rdx(OFS_RX_PORT, {24'h0, base});
    rdx(OFS_RX_PORT, {24'h0, 8'(base + 8'h1)});
    rdx(OFS_RX_PORT, 32'h0);
    rdx(OFS_ACK_HIST, 32'h0003_ffff);
    // bus reset first, then a repeated start without a stop
    acc(1'b1, OFS_OPTIONS, 32'h3);
    acc(1'b1, OFS_TX_PORT, 32'h3c);
    exp_bus = '{9'h100, 9'h054, 9'h03c, 9'h055, 9'h100};
    run(16'd1, 16'd1);
    rdx(OFS_RX_PORT, {24'h0, base});
    rdx(OFS_ACK_HIST, 32'h001f_ffff);
    // read-only transaction drops the write address
    acc(1'b1, OFS_OPTIONS, 32'h0);
    exp_bus = '{9'h055, 9'h100};
    run(16'd0, 16'd2);
    rdx(OFS_RX_PORT, {24'h0, base});
    rdx(OFS_RX_PORT, {24'h0, 8'(base + 8'h1)});
    rdx(OFS_ACK_HIST, 32'h003f_ffff);
    // absent target: two sent bytes record no acknowledge; stretching ignored
    acc(1'b1, OFS_OPTIONS, 32'h4);
    acc(1'b1, OFS_ADDRESS, 32'h2b);
    acc(1'b1, OFS_TX_PORT, 32'h5a);
    exp_bus = '{9'h056, 9'h100};
    run(16'd1, 16'd0);
    rdx(OFS_ACK_HIST, 32'h00ff_fffc);
    @(posedge clk);
    #1;
    `CHK(exp_bus.size() + exp_reg.size(), 0)
    test_done();
  end
endmodule // test_imte_top
